// file: src/prs_params.svh
// Constants for the power rail fault supervisor
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_NCH          3
`define PRS_CLK_HZ       125000000
`define PRS_OC_WAIT_MS   200
`define PRS_SS_STEP_US   250
// Prescaler tick every 250 us (also base of the 200 ms restart wait)
`define PRS_TICK_CYC     ((`PRS_CLK_HZ / 1000000) * `PRS_SS_STEP_US)
`define PRS_OC_TICKS     ((`PRS_OC_WAIT_MS * 1000) / `PRS_SS_STEP_US)
`define PRS_ILIM_LO      5
`define PRS_ILIM_HI      0
`define PRS_ILIM_WM_HI   7
`define PRS_ILIM_WM_LO   6
`define PRS_TEMP_BASE_K  200
`define PRS_TEMP_STEP_K  5
`define PRS_TEMP_MAX_K   520
`define PRS_OTW_NARROW   7'h01
`define PRS_OTW_WIDE     7'h02
`define PRS_OV_LOW_TARG  8'h32
`define PRS_SS_DLY_HI    15
`define PRS_SS_DLY_LO    10
`define PRS_OC_WARN_STEP 6'h02
`endif

// file: src/prs_pkg.sv
// Types for the power rail fault supervisor
package prs_pkg;
	typedef enum logic [1:0] {CH_OFF, CH_DELAY, CH_RUN, CH_OCWAIT} prs_ch_t;
	typedef logic [2:0] prs_mask_t;
endpackage

// file: src/prs_supervisor.sv
// Fault supervision of input, temperature, and three output channels
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module prs_supervisor (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	input  wire logic [7:0]            measured_input_voltage,
	input  wire logic [7:0]            input_warn_threshold,
	input  wire logic [7:0]            input_fault_threshold,
	input  wire logic                  input_restart_en,
	input  wire logic [6:0]            junction_temperature,
	input  wire logic [6:0]            thermal_shutdown_threshold,
	input  wire logic [6:0]            thermal_restart_threshold,
	input  wire logic                  temp_warn_wide,
	input  wire logic                  temp_restart_en,
	input  wire logic [23:0]           output_target_code,
	input  wire logic [23:0]           measured_output_voltage,
	input  wire logic [23:0]           overvoltage_threshold_select,
	input  wire logic [2:0]            ov_forced_mode,
	input  wire logic [7:0]            follower_config_low,
	input  wire logic [7:0]            follower_config_high,
	input  wire logic [23:0]           current_limit_config,
	input  wire logic [17:0]           current_sense_level,
	input  wire logic [47:0]           soft_start_config,
	input  wire logic [2:0]            channel_enable,
	input  wire logic [15:0]           gpio_route_select,
	output logic                       gpio_fault_out,
	output logic [7:0]                 volt_temp_flags,
	output logic [2:0]                 overcurrent_warning_flags,
	output logic [2:0]                 overcurrent_fault_flags,
	output logic [7:0]                 input_voltage_readback,
	output logic [9:0]                 junction_temp_kelvin,
	output prs_pkg::prs_mask_t         pulse_enable,
	output prs_pkg::prs_mask_t         low_side_gate
);
	import prs_pkg::*;

	localparam int TICK_CYC = `PRS_TICK_CYC;
	localparam int OC_TICKS = `PRS_OC_TICKS;

	// Per-channel follower mask; channel N's followers in low bits of nibble N
	function automatic prs_mask_t followers(input int ch);
		logic [15:0] cfg;
		cfg = {follower_config_high, follower_config_low};
		followers = cfg[ch*4 +: 3];
	endfunction

	// overvoltage trip level in 50mV target codes
	function automatic logic [8:0] ov_level(input logic [7:0] targ,
		input logic [7:0] sel);
		logic [8:0] ofs;
		ofs = 9'({6'h00, sel[1:0]} + 9'h003);
		if (targ > `PRS_OV_LOW_TARG)
			ofs = 9'(ofs << 1);
		ov_level = 9'({1'b0, targ} + ofs);
	endfunction

	logic        uv_flag_reg, uv_flag_next;
	logic        ot_flag_reg, ot_flag_next;
	logic        uv_fault, uv_warn, ot_fault, ot_warn;
	logic [6:0]  ot_margin;
	logic [17:0] tick_cnt_reg, tick_cnt_next;
	logic        tick;
	logic        global_off;
	prs_mask_t   ov_trip, oc_trip, ovf_reg, ovf_next, ocf_reg, ocf_next;
	prs_mask_t   ov_kill, oc_kill, forced_reg, forced_next, en_prev_reg;
	prs_mask_t   ocw, resume_reg, resume_next;
	prs_ch_t     st_reg [`PRS_NCH];
	prs_ch_t     st_next[`PRS_NCH];
	logic [10:0] cnt_reg [`PRS_NCH];
	logic [10:0] cnt_next[`PRS_NCH];

	assign uv_fault = measured_input_voltage < input_fault_threshold;
	assign uv_warn  = measured_input_voltage <= input_warn_threshold;
	assign ot_margin = temp_warn_wide ? `PRS_OTW_WIDE : `PRS_OTW_NARROW;
	assign ot_fault = junction_temperature >= thermal_shutdown_threshold;
	assign ot_warn  = 8'(junction_temperature) + 8'(ot_margin)
		>= 8'(thermal_shutdown_threshold);

	assign tick = tick_cnt_reg == 18'(TICK_CYC - 1);
	always_comb begin
		tick_cnt_next = tick ? 18'h00000 : 18'(tick_cnt_reg + 18'h00001);
	end

	always_comb begin
		uv_flag_next = uv_flag_reg;
		ot_flag_next = ot_flag_reg;
		// input fault latch, restart above warn level
		if (uv_fault)
			uv_flag_next = 1'b1;
		else if (input_restart_en && !uv_warn)
			uv_flag_next = 1'b0;
		// thermal latch, restart below restart level
		if (ot_fault)
			ot_flag_next = 1'b1;
		else if (temp_restart_en &&
			junction_temperature < thermal_restart_threshold)
			ot_flag_next = 1'b0;
	end
	assign global_off = uv_flag_reg | ot_flag_reg;

	genvar g;
	generate
		for (g = 0; g < `PRS_NCH; g++) begin : g_cmp
			logic [7:0] lim;
			logic [7:0] sense;
			logic [7:0] wm;
			assign lim = {2'h0, current_limit_config[g*8+`PRS_ILIM_LO -:
				6]};
			assign sense = {2'h0, current_sense_level[g*6 +: 6]};
			// margin of 10..40mV as 2..8 codes
			assign wm = 8'(({6'h00, current_limit_config[g*8+`PRS_ILIM_WM_HI
				-: 2]} + 8'h01) * 8'(`PRS_OC_WARN_STEP));
			assign ocw[g] = sense + wm >= lim;
			assign oc_trip[g] = sense >= lim;
			assign ov_trip[g] = {1'b0, measured_output_voltage[g*8 +: 8]}
				>= ov_level(output_target_code[g*8 +: 8],
				overvoltage_threshold_select[g*8 +: 8]);
		end
	endgenerate

	always_comb begin
		ov_kill = '0;
		oc_kill = '0;
		for (int c = 0; c < `PRS_NCH; c++) begin
			if (ov_trip[c] && st_reg[c] != CH_OFF)
				ov_kill = ov_kill | followers(c) | prs_mask_t'(1 << c);
			if (oc_trip[c] && st_reg[c] == CH_RUN)
				oc_kill = oc_kill | followers(c) | prs_mask_t'(1 << c);
		end
		ovf_next = ovf_reg;
		ocf_next = ocf_reg | oc_kill;
		forced_next = forced_reg;
		resume_next = resume_reg;
		for (int c = 0; c < `PRS_NCH; c++) begin
			// flag raised once the channel is off
			if (ov_trip[c] && st_reg[c] == CH_OFF)
				ovf_next[c] = 1'b1;
			// forced low gate held until re-enable
			if (ov_kill[c] && ov_forced_mode[c])
				forced_next[c] = 1'b1;
			// resume channels stopped by a global fault
			if (global_off && st_reg[c] != CH_OFF)
				resume_next[c] = 1'b1;
			if (!channel_enable[c] || ov_kill[c])
				resume_next[c] = 1'b0;
			if (channel_enable[c] && !en_prev_reg[c]) begin
				ovf_next[c] = ovf_next[c] & ov_trip[c];
				ocf_next[c] = oc_kill[c];
				forced_next[c] = ov_kill[c] & ov_forced_mode[c];
			end
		end
		for (int c = 0; c < `PRS_NCH; c++) begin
			st_next[c] = st_reg[c];
			cnt_next[c] = cnt_reg[c];
			case (st_reg[c])
			CH_OFF: begin
				if (channel_enable[c] && !global_off &&
					(!en_prev_reg[c] || resume_reg[c])) begin
					st_next[c] = CH_DELAY;
					cnt_next[c] = '0;
					resume_next[c] = 1'b0;
				end
			end
			CH_DELAY: begin
				if (11'(soft_start_config[c*16+`PRS_SS_DLY_HI -: 6]) <=
					cnt_reg[c])
					st_next[c] = CH_RUN;
				else if (tick)
					cnt_next[c] = 11'(cnt_reg[c] + 11'h001);
			end
			CH_RUN: ;
			CH_OCWAIT: begin
				if (cnt_reg[c] >= 11'(OC_TICKS)) begin
					st_next[c] = CH_DELAY;
					cnt_next[c] = '0;
				end else if (tick)
					cnt_next[c] = 11'(cnt_reg[c] + 11'h001);
			end
			default: st_next[c] = CH_OFF;
			endcase
			// global shutdown; ovp keeps channel off
			if (global_off || ov_kill[c] || !channel_enable[c]) begin
				st_next[c] = CH_OFF;
			end else if (oc_kill[c]) begin
				st_next[c] = CH_OCWAIT;
				cnt_next[c] = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			uv_flag_reg <= 1'b0;
			ot_flag_reg <= 1'b0;
			tick_cnt_reg <= '0;
			ovf_reg <= '0;
			ocf_reg <= '0;
			forced_reg <= '0;
			en_prev_reg <= '0;
			resume_reg <= '0;
			for (int c = 0; c < `PRS_NCH; c++) begin
				st_reg[c] <= CH_OFF;
				cnt_reg[c] <= '0;
			end
		end else begin
			uv_flag_reg <= uv_flag_next;
			ot_flag_reg <= ot_flag_next;
			tick_cnt_reg <= tick_cnt_next;
			ovf_reg <= ovf_next;
			ocf_reg <= ocf_next;
			forced_reg <= forced_next;
			en_prev_reg <= channel_enable;
			resume_reg <= resume_next;
			for (int c = 0; c < `PRS_NCH; c++) begin
				st_reg[c] <= st_next[c];
				cnt_reg[c] <= cnt_next[c];
			end
		end
	end

	logic [7:0]  flags_next;
	logic        gpio_next;
	logic [15:0] cond;
	logic [9:0]  tk_next;
	always_comb begin
		// thermal fault also raises warning bit
		flags_next = {ovf_reg, uv_warn, uv_flag_reg, 1'b0,
			ot_warn | ot_flag_reg, ot_flag_reg};
		cond = {2'h0, ocw, ocf_reg, flags_next};
		gpio_next = |(cond & gpio_route_select);
		// kelvin readback; codes past 520 K clamp there
		tk_next = 10'(`PRS_TEMP_BASE_K) + 10'(junction_temperature) *
			10'(`PRS_TEMP_STEP_K);
		if (tk_next > 10'(`PRS_TEMP_MAX_K))
			tk_next = 10'(`PRS_TEMP_MAX_K);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			volt_temp_flags <= '0;
			overcurrent_warning_flags <= '0;
			overcurrent_fault_flags <= '0;
			input_voltage_readback <= '0;
			junction_temp_kelvin <= '0;
			gpio_fault_out <= 1'b0;
			pulse_enable <= '0;
			low_side_gate <= '0;
		end else begin
			volt_temp_flags <= flags_next;
			overcurrent_warning_flags <= ocw;
			overcurrent_fault_flags <= ocf_reg;
			input_voltage_readback <= measured_input_voltage;
			junction_temp_kelvin <= tk_next;
			gpio_fault_out <= gpio_next;
			for (int c = 0; c < `PRS_NCH; c++) begin
				pulse_enable[c] <= st_reg[c] == CH_RUN;
				low_side_gate[c] <= forced_reg[c];
			end
		end
	end

	a_ocwait_no_pulse:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		st_reg[2] == CH_OCWAIT |=> !pulse_enable[2])
		else $error("pulses during restart wait");
	a_uv_all_off:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		uv_flag_reg |=> ##1 pulse_enable == 3'h0)
		else $error("channel on during input fault");
	a_ot_both_bits:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		ot_flag_reg |=> volt_temp_flags[1:0] == 2'b11)
		else $error("thermal bits missing");
	a_ov_flag_set:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		ov_trip[0] && st_reg[0] == CH_OFF |=> ovf_reg[0])
		else $error("ov flag not set");
	a_ov_follow_off:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		ov_kill[1] |=> st_reg[1] == CH_OFF)
		else $error("follower not off");
	a_forced_gate:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		ov_kill[0] && ov_forced_mode[0] |=> ##1 low_side_gate[0])
		else $error("low gate not forced");
	a_oc_warn_track:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		1'b1 |=> overcurrent_warning_flags == $past(ocw))
		else $error("oc warning mismatch");
	a_oc_flag_set:
		assert property (@(posedge clk_sys) disable iff (!rst_b)
		oc_kill[2] |=> ocf_reg[2] && st_reg[2] != CH_RUN)
		else $error("oc fault not handled");
	c_oc_restart: cover property (@(posedge clk_sys)
		st_reg[0] == CH_OCWAIT ##1 st_reg[0] == CH_DELAY);
	c_uv_fault: cover property (@(posedge clk_sys) uv_flag_reg);
	c_ov_trip: cover property (@(posedge clk_sys) |ov_kill);
endmodule
`default_nettype wire

// file: tb/prs_plant_model.sv
// Rail plant model: output voltage and sensed current of three channels
`timescale 1ns/1ps
`default_nettype none
module prs_plant_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [2:0]  pulse_enable,
	input  wire logic [23:0] output_target_code,
	input  wire logic [2:0]  ov_inject,
	input  wire logic [17:0] load_level,
	output logic      [23:0] measured_output_voltage,
	output logic      [17:0] current_sense_level
);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			measured_output_voltage <= '0;
			current_sense_level <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (pulse_enable[c]) begin
					measured_output_voltage[8*c+:8] <=
						output_target_code[8*c+:8]
						+ (ov_inject[c] ? 8'h0a : 8'h00);
				end else if (measured_output_voltage[8*c+:8] != 8'h00) begin
					// A stopped rail discharges instead of holding its level
					measured_output_voltage[8*c+:8] <=
						measured_output_voltage[8*c+:8] - 8'h01;
				end
				// No switching means no current through the low-side switch
				current_sense_level[6*c+:6] <= pulse_enable[c] ?
					load_level[6*c+:6] : 6'h00;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the power rail fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import prs_pkg::*;
	logic        clk_sys, rst_b, uv_re, twide, tre, gpio_fault_out;
	logic [7:0]  supply_input_pin, warn, flt, fl_lo, fl_hi, volt_temp_flags, vin_rb;
	logic [6:0]  tj, tsh, trs;
	logic [23:0] tgt, ovsel, ilim, vout;
	logic [2:0]  forced, en, ovi, ocw, ocf;
	logic [17:0] load, isense;
	logic [47:0] ss;
	logic [15:0] route;
	logic [9:0]  junction_temp_kelvin;
	prs_mask_t   pulse_enable, low_side_gate;
	int          error_cnt = 0;
	int          checked = 0;

	prs_supervisor dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.measured_input_voltage(supply_input_pin), .input_warn_threshold(warn),
		.input_fault_threshold(flt), .input_restart_en(uv_re),
		.junction_temperature(tj), .thermal_shutdown_threshold(tsh),
		.thermal_restart_threshold(trs), .temp_warn_wide(twide),
		.temp_restart_en(tre), .output_target_code(tgt),
		.measured_output_voltage(vout), .overvoltage_threshold_select(ovsel),
		.ov_forced_mode(forced), .follower_config_low(fl_lo),
		.follower_config_high(fl_hi), .current_limit_config(ilim),
		.current_sense_level(isense), .soft_start_config(ss),
		.channel_enable(en), .gpio_route_select(route),
		.gpio_fault_out(gpio_fault_out), .volt_temp_flags(volt_temp_flags),
		.overcurrent_warning_flags(ocw), .overcurrent_fault_flags(ocf),
		.input_voltage_readback(vin_rb),
		.junction_temp_kelvin(junction_temp_kelvin),
		.pulse_enable(pulse_enable), .low_side_gate(low_side_gate));

	prs_plant_model plant (.clk_sys(clk_sys), .rst_b(rst_b),
		.pulse_enable(pulse_enable),
		.output_target_code(tgt), .ov_inject(ovi), .load_level(load),
		.measured_output_voltage(vout), .current_sense_level(isense));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [8:0] exp, got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_k(input string nm, input logic [9:0] exp, got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Start delay may last up to one 250 us prescaler tick
	task automatic wait_pe(input logic [2:0] m);
		int k;
		k = 0;
		while (pulse_enable !== m && k < 33000) begin
			@(negedge clk_sys);
			k++;
		end
		chk("pulse_enable", {6'h0, m}, {6'h0, pulse_enable});
	endtask

	task automatic print_verdict();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The run lasts just over one soft-start tick; past 40000 cycles it is a hang
	initial begin
		repeat (40000) @(posedge clk_sys);
		error_cnt++;
		print_verdict();
	end

	initial begin
		{rst_b, supply_input_pin, warn, flt, uv_re} = {1'b0, 8'h78, 8'h32, 8'h2d, 1'b1};
		{tj, tsh, trs, twide, tre} = {7'h00, 7'h50, 7'h46, 1'b0, 1'b0};
		// channel 2 set for an external divider
		tgt = {8'h32, 8'h14, 8'h14};
		{ovsel, forced, fl_lo, fl_hi} = {24'h0, 3'b001, 8'h02, 8'h02};
		// channel 0 waits one prescaler tick before pulses
		{ilim, ss, en, route} = {24'h283f3f, 48'h000000000400, 3'b000,
			16'h0010};
		{ovi, load} = {3'b000, 18'h0};
		cyc(2);
		chk("pulse_in_reset", 9'h0, {6'h0, pulse_enable});
		rst_b = 1'b1;
		cyc(2);
		chk("vin_readback", 9'h078, {1'b0, vin_rb});
		chk_k("temp_min", 10'h0c8, junction_temp_kelvin);
		tj = 7'h40;
		cyc(2);
		chk_k("temp_max", 10'h208, junction_temp_kelvin);
		{tj, en} = {7'h3c, 3'b111};
		cyc(5);
		chk("ss_delay_held", 9'h006, {6'h0, pulse_enable});
		wait_pe(3'b111);
		ss = 48'h0;
		supply_input_pin = 8'h31;
		cyc(3);
		chk("uv_warn", 9'h010, {1'b0, volt_temp_flags});
		chk("gpio_uv_warn", 9'h1, {8'h0, gpio_fault_out});
		supply_input_pin = 8'h2c;
		cyc(3);
		chk("uv_fault", 9'h1, {8'h0, volt_temp_flags[3]});
		chk("uv_all_off", 9'h0, {6'h0, pulse_enable});
		supply_input_pin = 8'h78;
		wait_pe(3'b111);
		tj = 7'h4e;
		cyc(3);
		chk("ot_below_narrow", 9'h0, {1'b0, volt_temp_flags});
		tj = 7'h4f;
		cyc(3);
		chk("ot_warn_narrow", 9'h002, {1'b0, volt_temp_flags});
		{tj, twide} = {7'h4e, 1'b1};
		cyc(3);
		chk("ot_warn_wide", 9'h1, {8'h0, volt_temp_flags[1]});
		{tj, twide} = {7'h50, 1'b0};
		cyc(3);
		chk("ot_fault", 9'h3, {7'h0, volt_temp_flags[1:0]});
		chk("ot_all_off", 9'h0, {6'h0, pulse_enable});
		{tj, tre} = {7'h3c, 1'b1};
		wait_pe(3'b111);
		ovi = 3'b001;
		cyc(4);
		chk("ov_flag", 9'h020, {1'b0, volt_temp_flags});
		chk("ov_follower_off", 9'h004, {6'h0, pulse_enable});
		chk("forced_gate", 9'h001, {6'h0, low_side_gate});
		ovi = 3'b000;
		cyc(20);
		chk("ov_stays_off", 9'h004, {6'h0, pulse_enable});
		en = 3'b100;
		cyc(2);
		en = 3'b111;
		cyc(3);
		chk("gate_release", 9'h0, {6'h0, low_side_gate});
		chk("ov_flag_clear", 9'h0, {1'b0, volt_temp_flags});
		load = {6'h27, 12'h0};
		cyc(3);
		chk("oc_warn", 9'h004, {6'h0, ocw});
		chk("oc_no_fault", 9'h0, {6'h0, ocf});
		load = {6'h29, 12'h0};
		cyc(4);
		// Follower channel 1 is flagged along with the tripped channel
		chk("oc_fault", 9'h006, {6'h0, ocf});
		chk("oc_off", 9'h0, {6'h0, pulse_enable & 3'b110});
		cyc(3);
		chk("oc_warn_clear", 9'h0, {6'h0, ocw});
		print_verdict();
	end
endmodule
`default_nettype wire
